// >>> hw/emc_pkg.sv
package emc_pkg;

   // ----------------------------------------
   // Output modes
   // ----------------------------------------
   typedef enum logic [2:0]
   {
      EMC_MODE_RUN = 3'h1,
      EMC_MODE_LOW = 3'h2,
      EMC_MODE_HIZ = 3'h4
   } emc_mode_t;

   // ----------------------------------------
   // Divide selections for output B
   // ----------------------------------------
   typedef enum logic [2:0]
   {
      EMC_DIV1 = 3'h1,
      EMC_DIV2 = 3'h2,
      EMC_DIV4 = 3'h4
   } emc_div_t;

   // ----------------------------------------
   // Control port encodings
   // ----------------------------------------
   localparam logic [1:0] EMC_CTRL_RUN  = 2'h0;
   localparam logic [1:0] EMC_CTRL_LOW  = 2'h1;
   localparam logic [1:0] EMC_CTRL_HIZ  = 2'h2;
   localparam logic [1:0] EMC_CODE_DIV1 = 2'h0;
   localparam logic [1:0] EMC_CODE_DIV2 = 2'h1;
   localparam logic [1:0] EMC_CODE_DIV4 = 2'h2;

   // ----------------------------------------
   // Reset values, divide counter step and divide bit indices
   // ----------------------------------------
   localparam logic       EMC_LEVEL_LOW = 1'h0;
   localparam logic       EMC_OE_ON     = 1'h1;
   localparam logic [1:0] EMC_CNT_INIT  = 2'h0;
   localparam logic [1:0] EMC_CNT_STEP  = 2'h1;
   localparam int         EMC_CNT_DIV2  = 0;
   localparam int         EMC_CNT_DIV4  = 1;

endpackage : emc_pkg

// >>> hw/emc_src_if.sv
`timescale 1ns/100ps
interface emc_src_if;
   logic srcLevel;
   logic srcRise;
   logic srcDiv2;
   logic srcDiv4;
   logic selLevel;
   logic strapLevel;

   modport source
   (
      output srcLevel,
      output srcRise,
      output srcDiv2,
      output srcDiv4,
      output selLevel,
      output strapLevel
   );

   modport user
   (
      input  srcLevel,
      input  srcRise,
      input  srcDiv2,
      input  srcDiv4,
      input  selLevel,
      input  strapLevel
   );
endinterface : emc_src_if

// >>> hw/emc_src_divider.sv
`timescale 1ns/100ps
module emc_src_divider
(
   // Clock
   input  wire logic  mclk,
   // Pins
   input  wire logic  internal_system_clock_three,
   input  wire logic  external_source_clock_in,
   input  wire logic  mem_clock_source_select,
   input  wire logic  boot_strap_pin,
   // To selector
   emc_src_if.source  srcIf
);

   // ----------------------------------------
   // Synchronisers, free running through reset
   // ----------------------------------------
   logic [1:0] sysSync_q   = '0;
   logic [1:0] extSync_q   = '0;
   logic [1:0] selSync_q   = '0;
   logic [1:0] strapSync_q = '0;
   logic       srcPrev_q   = 1'h0;
   logic [1:0] divCnt_q    = emc_pkg::EMC_CNT_INIT;
   logic       srcLevel;
   logic       srcRise;

   always_ff @(posedge mclk)
   begin
      sysSync_q   <= {sysSync_q[0], internal_system_clock_three};
      extSync_q   <= {extSync_q[0], external_source_clock_in};
      selSync_q   <= {selSync_q[0], mem_clock_source_select};
      strapSync_q <= {strapSync_q[0], boot_strap_pin};
   end

   // ----------------------------------------
   // Source select and divide chain
   // ----------------------------------------
   assign srcLevel = selSync_q[1] ? extSync_q[1] : sysSync_q[1];
   assign srcRise  = srcLevel & ~srcPrev_q;

   always_ff @(posedge mclk)
   begin
      srcPrev_q <= srcLevel;
      if (srcRise)
         divCnt_q <= divCnt_q + emc_pkg::EMC_CNT_STEP;
   end

   assign srcIf.srcLevel   = srcLevel;
   assign srcIf.srcRise    = srcRise;
   assign srcIf.srcDiv2    = divCnt_q[emc_pkg::EMC_CNT_DIV2];
   assign srcIf.srcDiv4    = divCnt_q[emc_pkg::EMC_CNT_DIV4];
   assign srcIf.selLevel   = selSync_q[1];
   assign srcIf.strapLevel = strapSync_q[1];

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_srcFollowsExt;
      @(posedge mclk) selSync_q[1] |-> (srcLevel == $past(external_source_clock_in, 2));
   endproperty
   a_srcFollowsExt: assert property (p_srcFollowsExt) else $error("source not external clock");

   property p_divChain;
      @(posedge mclk) srcRise && divCnt_q[emc_pkg::EMC_CNT_DIV2]
         |=> (divCnt_q[emc_pkg::EMC_CNT_DIV4] != $past(divCnt_q[emc_pkg::EMC_CNT_DIV4]))
             && !divCnt_q[emc_pkg::EMC_CNT_DIV2];
   endproperty
   a_divChain: assert property (p_divChain) else $error("divide chain broken");

endmodule : emc_src_divider

// >>> hw/emc_clock_output_select.sv
`timescale 1ns/100ps
module emc_clock_output_select
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // Clock source pins
   input  wire logic        internal_system_clock_three,
   input  wire logic        external_source_clock_in,
   input  wire logic        mem_clock_source_select,
   input  wire logic        boot_strap_pin,
   // Control for output A
   input  wire logic        ctrlAWrite,
   input  wire logic [1:0]  ctrlAMode,
   // Control for output B
   input  wire logic        ctrlBWrite,
   input  wire logic [1:0]  ctrlBMode,
   input  wire logic [1:0]  ctrlBDivide,
   // Output A pin
   output logic             ext_mem_clock_out_a,
   output logic             extMemClockOutAOe,
   // Output B pin
   output logic             ext_mem_clock_out_b,
   output logic             extMemClockOutBOe,
   // Status
   output emc_pkg::emc_mode_t modeAState,
   output emc_pkg::emc_mode_t modeBState,
   output emc_pkg::emc_div_t  divBState,
   output logic             strapState
);

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   function automatic emc_pkg::emc_mode_t emc_decode_mode(input logic [1:0] code);
      emc_pkg::emc_mode_t m;
      m = emc_pkg::EMC_MODE_RUN;
      if (code == emc_pkg::EMC_CTRL_LOW)
         m = emc_pkg::EMC_MODE_LOW;
      else if (code == emc_pkg::EMC_CTRL_HIZ)
         m = emc_pkg::EMC_MODE_HIZ;
      return m;
   endfunction : emc_decode_mode

   function automatic emc_pkg::emc_div_t emc_decode_div(input logic [1:0] code);
      emc_pkg::emc_div_t d;
      d = emc_pkg::EMC_DIV4;
      if (code == emc_pkg::EMC_CODE_DIV1)
         d = emc_pkg::EMC_DIV1;
      else if (code == emc_pkg::EMC_CODE_DIV2)
         d = emc_pkg::EMC_DIV2;
      return d;
   endfunction : emc_decode_div

   // ----------------------------------------
   // Source and divider
   // ----------------------------------------
   emc_src_if srcIf ();

   emc_src_divider u_divider
   (
      .mclk                        (mclk),
      .internal_system_clock_three (internal_system_clock_three),
      .external_source_clock_in    (external_source_clock_in),
      .mem_clock_source_select     (mem_clock_source_select),
      .boot_strap_pin              (boot_strap_pin),
      .srcIf                       (srcIf)
   );

   // ----------------------------------------
   // Reset tracking and strap capture
   // ----------------------------------------
   logic               inReset_q;
   logic               strapHeld_q = 1'h0;
   logic               selHeld_q   = 1'h0;
   emc_pkg::emc_mode_t modeA_q;
   emc_pkg::emc_mode_t modeB_q;
   emc_pkg::emc_div_t  divB_q;
   logic               quietBoot;

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         inReset_q <= 1'h1;
      else
         inReset_q <= 1'h0;
   end

   always_ff @(posedge mclk)
   begin
      if (inReset_q)
      begin
         strapHeld_q <= srcIf.strapLevel;
         selHeld_q   <= srcIf.selLevel;
      end
   end

   assign quietBoot = !srcIf.strapLevel && !srcIf.selLevel;

   // ----------------------------------------
   // Mode registers
   // ----------------------------------------
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         modeA_q <= emc_pkg::EMC_MODE_HIZ;
         modeB_q <= emc_pkg::EMC_MODE_RUN;
         divB_q  <= emc_pkg::EMC_DIV4;
      end
      else if (inReset_q)
      begin
         modeA_q <= quietBoot ? emc_pkg::EMC_MODE_HIZ : emc_pkg::EMC_MODE_RUN;
         modeB_q <= quietBoot ? emc_pkg::EMC_MODE_LOW : emc_pkg::EMC_MODE_RUN;
         divB_q  <= emc_pkg::EMC_DIV4;
      end
      else
      begin
         if (ctrlAWrite)
            modeA_q <= emc_decode_mode(ctrlAMode);
         if (ctrlBWrite)
         begin
            modeB_q <= emc_decode_mode(ctrlBMode);
            divB_q  <= emc_decode_div(ctrlBDivide);
         end
      end
   end

   // ----------------------------------------
   // Output selection
   // ----------------------------------------
   logic divBLevel;
   logic outA_d;
   logic oeA_d;
   logic outB_d;
   logic oeB_d;

   assign divBLevel = (divB_q == emc_pkg::EMC_DIV1) ? srcIf.srcLevel :
                      (divB_q == emc_pkg::EMC_DIV2) ? srcIf.srcDiv2 : srcIf.srcDiv4;
   assign outA_d    = (modeA_q == emc_pkg::EMC_MODE_RUN) && srcIf.srcLevel;
   assign oeA_d     = (modeA_q != emc_pkg::EMC_MODE_HIZ);
   assign outB_d    = inReset_q ? srcIf.srcDiv4 :
                      ((modeB_q == emc_pkg::EMC_MODE_RUN) && divBLevel);
   assign oeB_d     = inReset_q || (modeB_q != emc_pkg::EMC_MODE_HIZ);

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         ext_mem_clock_out_a <= emc_pkg::EMC_LEVEL_LOW;
         extMemClockOutAOe   <= emc_pkg::EMC_LEVEL_LOW;
         extMemClockOutBOe   <= emc_pkg::EMC_OE_ON;
      end
      else
      begin
         ext_mem_clock_out_a <= outA_d;
         extMemClockOutAOe   <= oeA_d;
         extMemClockOutBOe   <= oeB_d;
      end
   end

   // Output B keeps dividing while reset is held
   logic outB_q = 1'h0;

   always_ff @(posedge mclk)
   begin
      outB_q <= outB_d;
   end

   assign ext_mem_clock_out_b = outB_q;
   assign modeAState          = modeA_q;
   assign modeBState          = modeB_q;
   assign divBState           = divB_q;
   assign strapState          = strapHeld_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_aHizInReset;
      @(posedge mclk) inReset_q |-> !extMemClockOutAOe;
   endproperty
   a_aHizInReset: assert property (p_aHizInReset) else $error("output A driven in reset");

   property p_bDriveInReset;
      @(posedge mclk) disable iff (!inReset_q) inReset_q |=> extMemClockOutBOe && (outB_q == $past(srcIf.srcDiv4));
   endproperty
   a_bDriveInReset: assert property (p_bDriveInReset) else $error("output B not dividing in reset");

   property p_quietDefaults;
      @(posedge mclk) disable iff (reset) $fell(inReset_q) && !strapHeld_q && !selHeld_q
         |-> modeA_q == emc_pkg::EMC_MODE_HIZ && modeB_q == emc_pkg::EMC_MODE_LOW;
   endproperty
   a_quietDefaults: assert property (p_quietDefaults) else $error("quiet boot defaults wrong");

   property p_runDefaults;
      @(posedge mclk) disable iff (reset) $fell(inReset_q) && (strapHeld_q || selHeld_q)
         |-> modeA_q == emc_pkg::EMC_MODE_RUN && modeB_q == emc_pkg::EMC_MODE_RUN
             && divB_q == emc_pkg::EMC_DIV4;
   endproperty
   a_runDefaults: assert property (p_runDefaults) else $error("run boot defaults wrong");

   property p_bLowHeld;
      @(posedge mclk) disable iff (reset) !inReset_q && modeB_q == emc_pkg::EMC_MODE_LOW
         |=> extMemClockOutBOe && !outB_q;
   endproperty
   a_bLowHeld: assert property (p_bLowHeld) else $error("output B not held low");

   property p_bHiz;
      @(posedge mclk) disable iff (reset) !inReset_q && modeB_q == emc_pkg::EMC_MODE_HIZ |=> !extMemClockOutBOe;
   endproperty
   a_bHiz: assert property (p_bHiz) else $error("output B not released");

   property p_aLow;
      @(posedge mclk) disable iff (reset) modeA_q == emc_pkg::EMC_MODE_LOW
         |=> extMemClockOutAOe && !ext_mem_clock_out_a;
   endproperty
   a_aLow: assert property (p_aLow) else $error("output A not held low");

   property p_aFollows;
      @(posedge mclk) disable iff (reset) modeA_q == emc_pkg::EMC_MODE_RUN
         |=> extMemClockOutAOe && (ext_mem_clock_out_a == $past(srcIf.srcLevel));
   endproperty
   a_aFollows: assert property (p_aFollows) else $error("output A not following source");

   property p_bDiv2;
      @(posedge mclk) disable iff (reset) !inReset_q && modeB_q == emc_pkg::EMC_MODE_RUN
         && divB_q == emc_pkg::EMC_DIV2 |=> outB_q == $past(srcIf.srcDiv2);
   endproperty
   a_bDiv2: assert property (p_bDiv2) else $error("output B half rate wrong");

   property p_strapHeld;
      @(posedge mclk) disable iff (reset) !inReset_q |=> $stable(strapHeld_q);
   endproperty
   a_strapHeld: assert property (p_strapHeld) else $error("strap changed after reset");

endmodule : emc_clock_output_select

// >>> test/emc_mem_model.sv
`timescale 1ns/100ps
module emc_mem_model
(
   // Clock
   input  wire logic mclk,
   // Clock pin from the device
   input  wire logic clkPin,
   input  wire logic clkOe,
   // Measured period in mclk cycles
   output int        period
);
   logic prevLevel = 1'h0;
   int   runCnt    = 0;

   // Released or idle pin gives no period
   always @(posedge mclk)
   begin
      prevLevel <= clkPin;
      if (!clkOe || runCnt > 100)
      begin
         runCnt <= 0;
         period <= 0;
      end
      else if (clkPin && !prevLevel)
      begin
         period <= runCnt;
         runCnt <= 1;
      end
      else
         runCnt <= runCnt + 1;
   end
endmodule : emc_mem_model

// >>> test/ext_mem_clock_output_select_tb.sv
`timescale 1ns/100ps
module ext_mem_clock_output_select_tb;
   logic               mclk     = 1'h0;
   logic               reset    = 1'h1;
   logic               intClk   = 1'h0;
   logic               extClk   = 1'h0;
   logic               selPin   = 1'h0;
   logic               strapPin = 1'h0;
   logic               aWr      = 1'h0;
   logic               bWr      = 1'h0;
   logic [1:0]         aMode    = 2'h0;
   logic [1:0]         bMode    = 2'h0;
   logic [1:0]         bDiv     = 2'h0;
   logic               outA;
   logic               oeA;
   logic               outB;
   logic               oeB;
   logic               strapQ;
   emc_pkg::emc_mode_t modeA;
   emc_pkg::emc_mode_t modeB;
   emc_pkg::emc_div_t  divB;
   int                 perA;
   int                 perB;
   int                 src;
   int                 errorCnt    = 0;
   int                 totalChecks = 0;

   // Internal source 10 mclk, external 14 mclk
   always #10 mclk = ~mclk;
   always #100 intClk = ~intClk;
   always #140 extClk = ~extClk;

   emc_clock_output_select u_emc_clock_output_select
   (
      .mclk                        (mclk),
      .reset                       (reset),
      .internal_system_clock_three (intClk),
      .external_source_clock_in    (extClk),
      .mem_clock_source_select     (selPin),
      .boot_strap_pin              (strapPin),
      .ctrlAWrite                  (aWr),
      .ctrlAMode                   (aMode),
      .ctrlBWrite                  (bWr),
      .ctrlBMode                   (bMode),
      .ctrlBDivide                 (bDiv),
      .ext_mem_clock_out_a         (outA),
      .extMemClockOutAOe           (oeA),
      .ext_mem_clock_out_b         (outB),
      .extMemClockOutBOe           (oeB),
      .modeAState                  (modeA),
      .modeBState                  (modeB),
      .divBState                   (divB),
      .strapState                  (strapQ)
   );

   emc_mem_model u_mem_a (.mclk(mclk), .clkPin(outA), .clkOe(oeA), .period(perA));
   emc_mem_model u_mem_b (.mclk(mclk), .clkPin(outB), .clkOe(oeB), .period(perB));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task endSim;
      $display("checks %0d mismatches %0d", totalChecks, errorCnt);
      if (errorCnt == 0 && totalChecks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : endSim

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp)
      begin
         errorCnt++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check

   // Output edges jitter by one mclk
   task near(input string name, input int seen, input int exp);
      check(name, 32'((seen >= exp - 1 && seen <= exp + 1) ? exp : seen), 32'(exp));
   endtask : near

   task cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc

   task rstOn(input logic s, input logic l, input int n);
      strapPin = s;
      selPin   = l;
      reset    = 1'h1;
      cyc(n);
   endtask : rstOn

   task wrA(input logic [1:0] m);
      aWr   = 1'h1;
      aMode = m;
      cyc(1);
      aWr = 1'h0;
      cyc(150);
   endtask : wrA

   task wrB(input logic [1:0] m, input logic [1:0] d);
      bWr   = 1'h1;
      bMode = m;
      bDiv  = d;
      cyc(1);
      bWr = 1'h0;
      cyc(150);
   endtask : wrB

   initial
   begin
      repeat (20000) @(posedge mclk);
      errorCnt++;
      endSim();
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      cyc(5);
      reset = 1'h0;
      cyc(150);
      check("modeA", modeA, emc_pkg::EMC_MODE_HIZ);
      check("oeA", oeA, 1'h0);
      check("modeB", modeB, emc_pkg::EMC_MODE_LOW);
      check("oeB", oeB, 1'h1);
      check("outB", outB, 1'h0);
      check("perB", perB, 0);
      strapPin = 1'h1;
      cyc(5);
      check("strap", strapQ, 1'h0);
      rstOn(1'h0, 1'h0, 120);
      near("perB rst", perB, 40);
      check("oeA rst", oeA, 1'h0);
      reset = 1'h0;
      $display("test strap low defaults done");
      for (int i = 1; i < 4; i++)
      begin
         rstOn(i[0], i[1], 5);
         check("oeA rst", oeA, 1'h0);
         reset = 1'h0;
         cyc(150);
         src = i[1] ? 14 : 10;
         check("modeA", modeA, emc_pkg::EMC_MODE_RUN);
         check("modeB", modeB, emc_pkg::EMC_MODE_RUN);
         check("divB", divB, emc_pkg::EMC_DIV4);
         check("strap", strapQ, i[0]);
         near("perA", perA, src);
         near("perB", perB, 4 * src);
      end
      $display("test strap and select defaults done");
      for (int k = 0; k < 3; k++)
      begin
         wrB(emc_pkg::EMC_CTRL_RUN, 2'(k));
         check("divB", divB, 32'(1 << k));
         near("perB", perB, 14 * (1 << k));
      end
      selPin = 1'h0;
      cyc(150);
      near("perA", perA, 10);
      near("perB", perB, 40);
      $display("test divide and source done");
      wrB(emc_pkg::EMC_CTRL_LOW, emc_pkg::EMC_CODE_DIV1);
      check("modeB", modeB, emc_pkg::EMC_MODE_LOW);
      check("oeB", oeB, 1'h1);
      check("outB", outB, 1'h0);
      check("perB", perB, 0);
      wrB(emc_pkg::EMC_CTRL_HIZ, emc_pkg::EMC_CODE_DIV1);
      check("oeB", oeB, 1'h0);
      wrA(emc_pkg::EMC_CTRL_LOW);
      check("oeA", oeA, 1'h1);
      check("outA", outA, 1'h0);
      wrA(emc_pkg::EMC_CTRL_HIZ);
      check("oeA", oeA, 1'h0);
      // Unused code falls back to run
      wrA(2'h3);
      check("modeA", modeA, emc_pkg::EMC_MODE_RUN);
      check("oeA", oeA, 1'h1);
      wrA(emc_pkg::EMC_CTRL_RUN);
      near("perA", perA, 10);
      wrB(2'h3, 2'h3);
      check("modeB", modeB, emc_pkg::EMC_MODE_RUN);
      check("divB", divB, emc_pkg::EMC_DIV4);
      near("perB", perB, 40);
      $display("test hold and release done");
      endSim();
   end
endmodule : ext_mem_clock_output_select_tb
